// >>> core/rx_sample_timer.sv
// receive sample timer: start-bit wait, then one sample strobe per bit time
`timescale 1ns/1ps
`include "uart_flow_regs.svh"
module rx_sample_timer
  import uart_flow_pkg::*;
#(
  parameter int FRAME_BITS = 10
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         baudTick,
  input  wire logic         startEdge,
  input  wire start_delay_t startDelay,
  input  wire logic         highBaud,
  input  wire logic         oversample8,
  output logic              sampleStrobe,
  output logic              busy
);
  sample_state_e state_reg, state_next;
  logic [4:0]    cnt_reg, cnt_next;
  logic [4:0]    bitIdx_reg, bitIdx_next;
  logic          strobe_next;
  logic [4:0]    period;
  logic [4:0]    startTarget;

  always_comb begin
    period      = oversample8 ? `UF_BIT_CYCLES_8 : `UF_BIT_CYCLES_16;
    // mid-bit normally; high baud rates use the programmed wait instead
    startTarget = highBaud ? {1'b0, startDelay} : (period >> 1) - 5'h01;
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    bitIdx_next = bitIdx_reg;
    strobe_next = 1'b0;
    case (state_reg)
      TIMER_IDLE: begin
        if (startEdge) begin
          cnt_next   = 5'h00;
          state_next = TIMER_START;
        end
      end
      TIMER_START: begin
        if (baudTick) begin
          if (cnt_reg == startTarget) begin
            strobe_next = 1'b1;
            cnt_next    = 5'h00;
            bitIdx_next = 5'h01;
            state_next  = TIMER_BITS;
          end else begin
            cnt_next = cnt_reg + 5'h01;
          end
        end
      end
      TIMER_BITS: begin
        if (baudTick) begin
          if (cnt_reg == period - 5'h01) begin
            strobe_next = 1'b1;
            cnt_next    = 5'h00;
            if (bitIdx_reg == 5'(FRAME_BITS - 1)) begin
              state_next = TIMER_IDLE;
            end else begin
              bitIdx_next = bitIdx_reg + 5'h01;
            end
          end else begin
            cnt_next = cnt_reg + 5'h01;
          end
        end
      end
      default: state_next = TIMER_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg    <= TIMER_IDLE;
      cnt_reg      <= 5'h00;
      bitIdx_reg   <= 5'h00;
      sampleStrobe <= 1'b0;
      busy         <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      bitIdx_reg   <= bitIdx_next;
      sampleStrobe <= strobe_next;
      busy         <= (state_next != TIMER_IDLE);
    end
  end
endmodule

// >>> core/uart_flow_ctrl.sv
// uart flow control, start-bit timing, fifo trigger levels and their interrupt
//
// What this block does
// - with hardware request control on, assert request-to-send only while receive fifo has room.
// - with clear-to-send control on, start a character only while clear-to-send is asserted.
// - four-bit start-bit wait, bits 19:16, reset 0x4, sets receiver wait after start edge.
// - start-bit wait applies only with integer divisor 1 and eight-cycle oversampling.
// - transmit level field bits 2:0 picks empty fraction 1/64 to 3/4 for interrupt.
// - transmit level field resets to 0x2, one sixteenth empty.
// - receive level field bits 5:3 picks full fraction 1/64 to 3/4 for interrupt.
// - receive level field resets to 0x2, one sixteenth full.
// - oversample control gives sixteen cycles per bit when clear, eight when set.
// - disabling mid-character lets the current character finish first.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "uart_flow_regs.svh"
module uart_flow_ctrl
  import uart_flow_pkg::*;
#(
  parameter int FIFO_DEPTH = 64,
  parameter int LEVEL_W    = $clog2(FIFO_DEPTH) + 1,
  parameter int FRAME_BITS = 10
) (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic [7:0]         addr,
  input  wire logic [31:0]        wrData,
  input  wire logic               wrStrobe,
  input  wire logic               rdStrobe,
  output logic [31:0]             rdData,
  input  wire logic [15:0]        baudIntegerDivisor,
  input  wire logic               baudTick,
  input  wire logic [LEVEL_W-1:0] txFifoLevel,
  input  wire logic [LEVEL_W-1:0] rxFifoLevel,
  input  wire logic               txBusy,
  input  wire logic               ctsInN,
  input  wire logic               rxLine,
  output logic                    rtsOutN,
  output logic                    txStartAllowed,
  output logic                    txRun,
  output logic                    rxRun,
  output logic                    oversample8,
  output logic                    rxSampleStrobe,
  output logic                    rxBusy,
  output logic                    irqOut
);
  // fifo fill needed for a given trigger code; 111b falls back to the 3/4 point
  function automatic logic [LEVEL_W-1:0] trigger_threshold(input trigger_code_t code);
    logic [LEVEL_W-1:0] depth;
    depth = LEVEL_W'(FIFO_DEPTH);
    case (code)
      3'h0:    trigger_threshold = depth >> 6;
      3'h1:    trigger_threshold = depth >> 5;
      3'h2:    trigger_threshold = depth >> 4;
      3'h3:    trigger_threshold = depth >> 3;
      3'h4:    trigger_threshold = depth >> 2;
      3'h5:    trigger_threshold = depth >> 1;
      default: trigger_threshold = (depth >> 1) + (depth >> 2);
    endcase
  endfunction

  logic [31:0]        ctrl_reg, ctrl_next;
  logic [5:0]         level_reg, level_next;
  logic [31:0]        mask_reg, mask_next;
  logic [31:0]        status_reg, status_next;
  logic [31:0]        rdData_next;
  logic               irq_next;
  logic               ctsMeta_reg, ctsSync_reg;
  logic               rxMeta_reg, rxSync_reg, rxPrev_reg;
  logic               txHit_reg, rxHit_reg;
  logic               txHit, rxHit;
  logic               rts_next, cts_next, txRun_next, rxRun_next;
  logic               rxStartEdge;
  logic               highBaud;
  logic [LEVEL_W-1:0] txEmpty;
  logic [31:0]        events;
  logic               timerBusy;
  logic               timerStrobe;

  // register writes and reads
  always_comb begin
    ctrl_next   = ctrl_reg;
    level_next  = level_reg;
    mask_next   = mask_reg;
    rdData_next = 32'h0000_0000;
    if (wrStrobe) begin
      case (addr)
        `UF_CTRL_OFFSET:  ctrl_next = wrData & `UF_CTRL_WMASK;
        `UF_LEVEL_OFFSET: level_next = wrData[5:0];
        `UF_MASK_OFFSET:  mask_next = wrData & `UF_IRQ_WMASK;
        default:          ;
      endcase
    end
    if (rdStrobe) begin
      case (addr)
        `UF_CTRL_OFFSET:   rdData_next = ctrl_reg;
        `UF_LEVEL_OFFSET:  rdData_next = {26'h0000000, level_reg};
        `UF_MASK_OFFSET:   rdData_next = mask_reg;
        `UF_STATUS_OFFSET: rdData_next = status_reg;
        default:           rdData_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg  <= `UF_CTRL_RESET;
      level_reg <= `UF_LEVEL_RESET;
      mask_reg  <= 32'h0000_0000;
      rdData    <= 32'h0000_0000;
    end else begin
      ctrl_reg  <= ctrl_next;
      level_reg <= level_next;
      mask_reg  <= mask_next;
      rdData    <= rdData_next;
    end
  end

  // pin synchronisers; the first stage is never looked at
  always_ff @(posedge clk) begin
    if (srst) begin
      ctsMeta_reg <= 1'b1;
      ctsSync_reg <= 1'b1;
      rxMeta_reg  <= 1'b1;
      rxSync_reg  <= 1'b1;
      rxPrev_reg  <= 1'b1;
    end else begin
      ctsMeta_reg <= ctsInN;
      ctsSync_reg <= ctsMeta_reg;
      rxMeta_reg  <= rxLine;
      rxSync_reg  <= rxMeta_reg;
      rxPrev_reg  <= rxSync_reg;
    end
  end

  // trigger levels: level conditions, with rising edges as sticky events
  always_comb begin
    txEmpty = LEVEL_W'(FIFO_DEPTH) - txFifoLevel;
    txHit   = txEmpty >= trigger_threshold(level_reg[`UF_LEVEL_TX_MSB:`UF_LEVEL_TX_LSB]);
    rxHit   = rxFifoLevel >= trigger_threshold(level_reg[`UF_LEVEL_RX_MSB:`UF_LEVEL_RX_LSB]);
    events  = 32'h0000_0000;
    events[`UF_IRQ_TX_BIT] = txHit & ~txHit_reg;
    events[`UF_IRQ_RX_BIT] = rxHit & ~rxHit_reg;
    // an event landing on the clearing write survives it
    status_next = status_reg;
    if (wrStrobe && addr == `UF_STATUS_OFFSET) begin
      status_next = status_reg & ~(wrData & `UF_IRQ_WMASK);
    end
    status_next = status_next | events;
    irq_next    = |(status_next & mask_reg);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      txHit_reg  <= 1'b0;
      rxHit_reg  <= 1'b0;
      status_reg <= 32'h0000_0000;
      irqOut     <= 1'b0;
    end else begin
      txHit_reg  <= txHit;
      rxHit_reg  <= rxHit;
      status_reg <= status_next;
      irqOut     <= irq_next;
    end
  end

  // flow control and enables
  always_comb begin
    if (ctrl_reg[`UF_CTRL_AUTO_REQUEST_FLOW_ENABLE_BIT]) begin
      // pin is active low: low asks the partner to send
      rts_next = ~(rxFifoLevel < LEVEL_W'(FIFO_DEPTH));
    end else begin
      rts_next = ~ctrl_reg[`UF_CTRL_RTS_BIT];
    end
    cts_next = ~ctrl_reg[`UF_CTRL_AUTO_CLEAR_FLOW_ENABLE_BIT] | ~ctsSync_reg;
    // a character already in flight keeps its side running after disable
    txRun_next = (ctrl_reg[`UF_CTRL_ENABLE_BIT] & ctrl_reg[`UF_CTRL_TXE_BIT]) | txBusy;
    rxRun_next = (ctrl_reg[`UF_CTRL_ENABLE_BIT] & ctrl_reg[`UF_CTRL_RXE_BIT]) | timerBusy;
    highBaud   = (baudIntegerDivisor == 16'h0001) & ctrl_reg[`UF_CTRL_OVS_BIT];
    // new frames only start while enabled; the timer finishes on its own
    rxStartEdge = rxPrev_reg & ~rxSync_reg & ctrl_reg[`UF_CTRL_ENABLE_BIT] & ctrl_reg[`UF_CTRL_RXE_BIT];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rtsOutN        <= 1'b1;
      txStartAllowed <= 1'b1;
      txRun          <= 1'b0;
      rxRun          <= 1'b0;
      oversample8    <= 1'b0;
      rxSampleStrobe <= 1'b0;
      rxBusy         <= 1'b0;
    end else begin
      rtsOutN        <= rts_next;
      txStartAllowed <= cts_next;
      txRun          <= txRun_next;
      rxRun          <= rxRun_next;
      oversample8    <= ctrl_reg[`UF_CTRL_OVS_BIT];
      rxSampleStrobe <= timerStrobe;
      rxBusy         <= timerBusy;
    end
  end

  rx_sample_timer #(
    .FRAME_BITS (FRAME_BITS)
  ) sampleTimer (
    .clk          (clk),
    .srst         (srst),
    .baudTick     (baudTick),
    .startEdge    (rxStartEdge & ~timerBusy),
    .startDelay   (ctrl_reg[`UF_CTRL_DELAY_MSB:`UF_CTRL_DELAY_LSB]),
    .highBaud     (highBaud),
    .oversample8  (ctrl_reg[`UF_CTRL_OVS_BIT]),
    .sampleStrobe (timerStrobe),
    .busy         (timerBusy)
  );
endmodule

// >>> core/uart_flow_pkg.sv
// types shared by the flow-control block and its receive sample timer
package uart_flow_pkg;
  typedef enum logic [1:0] {
    TIMER_IDLE,
    TIMER_START,
    TIMER_BITS
  } sample_state_e;

  typedef logic [3:0] start_delay_t;
  typedef logic [2:0] trigger_code_t;
endpackage

// >>> core/uart_flow_regs.svh
// register offsets, field positions, reset values and timing counts of the flow-control block
`ifndef UART_FLOW_REGS_SVH
`define UART_FLOW_REGS_SVH

`define UF_CTRL_OFFSET     8'h30
`define UF_LEVEL_OFFSET    8'h34
`define UF_MASK_OFFSET     8'h38
`define UF_STATUS_OFFSET   8'h44

`define UF_CTRL_ENABLE_BIT   0
`define UF_CTRL_OVS_BIT      3
`define UF_CTRL_TXE_BIT      8
`define UF_CTRL_RXE_BIT      9
`define UF_CTRL_RTS_BIT      11
`define UF_CTRL_AUTO_REQUEST_FLOW_ENABLE_BIT    14
`define UF_CTRL_AUTO_CLEAR_FLOW_ENABLE_BIT    15
`define UF_CTRL_DELAY_LSB    16
`define UF_CTRL_DELAY_MSB    19
`define UF_LEVEL_TX_LSB      0
`define UF_LEVEL_TX_MSB      2
`define UF_LEVEL_RX_LSB      3
`define UF_LEVEL_RX_MSB      5
`define UF_IRQ_RX_BIT        4
`define UF_IRQ_TX_BIT        5

`define UF_CTRL_RESET      32'h0004_0300
`define UF_CTRL_WMASK      32'h000f_cb09
`define UF_LEVEL_RESET     6'h12
`define UF_IRQ_WMASK       32'h0000_0030

`define UF_BIT_CYCLES_16   5'h10
`define UF_BIT_CYCLES_8    5'h08

`endif

// >>> verif/remote_serial_model.sv
// remote serial device: frames on the receive line, clear-to-send output
`timescale 1ns/1ps
module remote_serial_model #(
  parameter int BIT_CYCLES = 8
) (
  input  wire logic       clk,
  input  wire logic       sendGo,
  input  wire logic [7:0] sendByte,
  input  wire logic       holdOff,
  input  wire logic       rtsOutN,
  output logic            ctsInN,
  output logic            rxLine,
  output logic            sending
);
  logic [9:0] frame = 10'h3ff;
  int         cyc = 0;
  int         bitCnt = 0;
  initial sending = 1'b0;
  initial ctsInN = 1'b1;
  // idle line rests at the pull-up level
  assign rxLine = sending ? frame[0] : 1'b1;
  always @(posedge clk) begin
    ctsInN <= holdOff;
    // a frame only starts while the block asks for data
    if (!sending && sendGo && !rtsOutN) begin
      frame <= {1'b1, sendByte, 1'b0};
      sending <= 1'b1;
      cyc <= 0;
      bitCnt <= 0;
    end else if (sending) begin
      cyc <= (cyc == BIT_CYCLES - 1) ? 0 : cyc + 1;
      if (cyc == BIT_CYCLES - 1) begin
        frame <= {1'b1, frame[9:1]};
        bitCnt <= bitCnt + 1;
        if (bitCnt == 9) sending <= 1'b0;
      end
    end
  end
endmodule

// >>> verif/tb_uart_flow_ctrl.sv
// self-checking bench for the flow-control block
`timescale 1ns/1ps
`include "uart_flow_regs.svh"
module tb_uart_flow_ctrl;
  localparam int FIFO_DEPTH = 64;
  typedef struct {logic [2:0] code; logic [6:0] thr;} level_row_s;
  level_row_s  rows [7] = '{'{3'h0, 7'h01}, '{3'h1, 7'h02}, '{3'h2, 7'h04}, '{3'h3, 7'h08},
                            '{3'h4, 7'h10}, '{3'h5, 7'h20}, '{3'h6, 7'h30}};
  logic        clk = 1'b0, srst = 1'b1, wrStrobe = 1'b0, rdStrobe = 1'b0, baudTick = 1'b1;
  logic        txBusy = 1'b0, sendGo = 1'b0, holdOff = 1'b0, ctsInN, rxLine, sending;
  logic        rtsOutN, txStartAllowed, txRun, rxRun, oversample8, rxSampleStrobe, rxBusy, irqOut;
  logic [7:0]  addr = 8'h0;
  logic [31:0] wrData = 32'h0, rdData, got;
  logic [15:0] baudIntegerDivisor = 16'h1;
  logic [6:0]  txFifoLevel = 7'h40, rxFifoLevel = 7'h0;
  int          nErrors = 0, testsRun = 0, n, k;
  // wait + 1 ticks, plus two sync stages, edge and output flops, from the first edge seeing the pin low
  int          firstExp [3] = '{11, 8, 12};
  initial forever #2.5 clk = ~clk;
  uart_flow_ctrl #(.FIFO_DEPTH(FIFO_DEPTH)) dut_u (.clk, .srst, .addr, .wrData, .wrStrobe, .rdStrobe,
    .rdData, .baudIntegerDivisor, .baudTick, .txFifoLevel, .rxFifoLevel, .txBusy, .ctsInN, .rxLine,
    .rtsOutN, .txStartAllowed, .txRun, .rxRun, .oversample8, .rxSampleStrobe, .rxBusy, .irqOut);
  remote_serial_model #(.BIT_CYCLES(8)) peer_u (.clk, .sendGo, .sendByte(8'h5a), .holdOff, .rtsOutN,
    .ctsInN, .rxLine, .sending);
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  // each access leaves a gap cycle so no strobe is driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    tick(1);
    wrStrobe <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rdStrobe <= 1'b1;
    tick(1);
    rdStrobe <= 1'b0;
    tick(1);
    d = rdData;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    testsRun++;
    if (g !== e) begin
      nErrors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic printVerdict();
    if (nErrors == 0 && testsRun > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // a wait that ran out of cycles is a mismatch and ends the run
  task automatic bailIf(input bit hit);
    if (hit) begin
      nErrors++;
      printVerdict();
    end
  endtask
  task automatic setLevel(input int isTx, input logic [6:0] v);
    rxFifoLevel <= isTx ? 7'h0 : v;
    txFifoLevel <= isTx ? 7'h40 - v : 7'h40;
    tick(3);
  endtask
  task automatic countStrobe(output int c);
    c = 0;
    do begin
      tick(1);
      c++;
    end while (rxSampleStrobe !== 1'b1 && c < 100);
    bailIf(c >= 100);
  endtask
  initial begin
    tick(6);
    srst <= 1'b0;
    tick(2);
    rd(`UF_CTRL_OFFSET, got); chk(got, 32'h0004_0300);
    rd(`UF_LEVEL_OFFSET, got); chk(got, 32'h12);
    rd(8'h3c, got); chk(got, 32'h0);
    // read data stands one cycle only
    rd(`UF_LEVEL_OFFSET, got);
    tick(1);
    chk(rdData, 32'h0);
    chk(rtsOutN, 1'b1);
    foreach (rows[i]) begin
      wr(`UF_LEVEL_OFFSET, {26'h0, rows[i].code, rows[i].code});
      for (int j = 0; j < 2; j++) begin
        wr(`UF_MASK_OFFSET, j ? 32'h20 : 32'h10);
        setLevel(j, 7'h0);
        wr(`UF_STATUS_OFFSET, 32'h30);
        setLevel(j, rows[i].thr - 7'h1); chk(irqOut, 1'b0);
        setLevel(j, rows[i].thr); chk(irqOut, 1'b1);
      end
    end
    wr(`UF_MASK_OFFSET, 32'h0);
    rd(`UF_STATUS_OFFSET, got);
    chk(got, 32'h20);
    wr(`UF_CTRL_OFFSET, 32'h0004_4300);
    rxFifoLevel <= 7'h3f; tick(3); chk(rtsOutN, 1'b0);
    rxFifoLevel <= 7'h40; tick(3); chk(rtsOutN, 1'b1);
    rxFifoLevel <= 7'h0;
    wr(`UF_CTRL_OFFSET, 32'h0004_8b00);
    tick(1);
    chk(rtsOutN, 1'b0);
    holdOff <= 1'b1; tick(5); chk(txStartAllowed, 1'b0);
    holdOff <= 1'b0; tick(5); chk(txStartAllowed, 1'b1);
    // wait of 6 fits the formula at divisor 1 with a fraction of 48 or more; it acts only with eight-cycle bits
    for (int c = 0; c < 3; c++) begin
      baudIntegerDivisor <= (c == 1) ? 16'h2 : 16'h1;
      wr(`UF_CTRL_OFFSET, {12'h0, 4'h6, 8'h0b, 4'h0, c != 2, 3'h1});
      sendGo <= 1'b1;
      tick(1);
      sendGo <= 1'b0;
      for (n = 0; n < 50 && rxLine !== 1'b0; n++) tick(1);
      bailIf(n >= 50);
      countStrobe(k); chk(k, firstExp[c]);
      countStrobe(k); chk(k, c == 2 ? 16 : 8);
      if (c == 2) begin
        // disable mid-frame: the receive side keeps running until the frame ends
        wr(`UF_CTRL_OFFSET, 32'h0006_0b00);
        tick(1);
        chk(rxRun, 1'b1);
      end
      for (n = 0; n < 400 && (rxBusy !== 1'b0 || sending); n++) tick(1);
      bailIf(n >= 400);
      chk(rxBusy, 1'b0);
      chk(rxRun, c != 2);
    end
    txBusy <= 1'b1;
    wr(`UF_CTRL_OFFSET, 32'h0);
    tick(3); chk(txRun, 1'b1);
    txBusy <= 1'b0;
    tick(3); chk(txRun, 1'b0);
    // reset in mid-run brings both registers back
    srst <= 1'b1;
    tick(2);
    srst <= 1'b0;
    rd(`UF_LEVEL_OFFSET, got);
    chk(got, 32'h12);
    rd(`UF_CTRL_OFFSET, got);
    chk(got, 32'h0004_0300);
    printVerdict();
  end
endmodule
bind uart_flow_ctrl uart_flow_ctrl_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (.clk, .srst, .addr, .wrData,
  .wrStrobe, .txFifoLevel, .rxFifoLevel, .txBusy, .ctsInN, .rtsOutN, .txStartAllowed, .txRun, .oversample8,
  .rxSampleStrobe, .irqOut);

// >>> verif/uart_flow_ctrl_asserts.sv
// port-level assertions for the flow-control block
`timescale 1ns/1ps
`include "uart_flow_regs.svh"
module uart_flow_ctrl_asserts #(
  parameter int FIFO_DEPTH = 64,
  parameter int LEVEL_W    = $clog2(FIFO_DEPTH) + 1
) (
  input wire logic               clk,
  input wire logic               srst,
  input wire logic [7:0]         addr,
  input wire logic [31:0]        wrData,
  input wire logic               wrStrobe,
  input wire logic [LEVEL_W-1:0] txFifoLevel,
  input wire logic [LEVEL_W-1:0] rxFifoLevel,
  input wire logic               txBusy,
  input wire logic               ctsInN,
  input wire logic               rtsOutN,
  input wire logic               txStartAllowed,
  input wire logic               txRun,
  input wire logic               oversample8,
  input wire logic               rxSampleStrobe,
  input wire logic               irqOut
);
  // shadow of written fields, since the block's registers are not visible at its ports
  logic       hwReq, swReq, auto_clear_flow_enable, ovs, mRx, mTx;
  logic [2:0] txCode, rxCode;
  wire        ctrlWr = wrStrobe && addr == `UF_CTRL_OFFSET;
  always_ff @(posedge clk) begin
    if (srst) begin
      {auto_clear_flow_enable, hwReq, swReq, ovs, mTx, mRx} <= 6'h0;
      {rxCode, txCode} <= 6'h12;
    end else if (wrStrobe) begin
      if (ctrlWr) {auto_clear_flow_enable, hwReq, swReq, ovs} <= {wrData[15:14], wrData[11], wrData[3]};
      if (addr == `UF_LEVEL_OFFSET) {rxCode, txCode} <= wrData[5:0];
      if (addr == `UF_MASK_OFFSET) {mTx, mRx} <= wrData[5:4];
    end
  end
  // reserved code 111b is taken as 3/4, as the block does
  function automatic int thr(logic [2:0] c);
    return (c >= 3'h6) ? FIFO_DEPTH * 3 / 4 : (FIFO_DEPTH / 64) << c;
  endfunction
  wire rxHit = int'(rxFifoLevel) >= thr(rxCode);
  wire txHit = FIFO_DEPTH - int'(txFifoLevel) >= thr(txCode);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_rts_hw: assert property (hwReq |=> rtsOutN == ($past(rxFifoLevel) >= FIFO_DEPTH))
    else $error("request line wrong under hardware control");
  chk_rts_sw: assert property (!hwReq |=> rtsOutN == !$past(swReq))
    else $error("request line does not follow software bit");
  chk_cts_block: assert property ((auto_clear_flow_enable && ctsInN) [*4] |-> !txStartAllowed)
    else $error("start allowed while clear-to-send negated");
  chk_cts_free: assert property (!auto_clear_flow_enable [*2] |-> txStartAllowed)
    else $error("start blocked with clear-to-send control off");
  chk_ovs_track: assert property (!ctrlWr [*2] |-> oversample8 == ovs)
    else $error("oversample output differs from control bit");
  chk_irq_event: assert property (($rose(rxHit) && mRx) || ($rose(txHit) && mTx) |=> irqOut)
    else $error("trigger level crossed without interrupt");
  chk_irq_masked: assert property (!(mRx || mTx) [*2] |-> !irqOut)
    else $error("interrupt with all sources masked");
  chk_strobe_gap: assert property (rxSampleStrobe |=> !rxSampleStrobe [*7])
    else $error("sample strobes closer than eight cycles");
  chk_tx_finish: assert property (txRun && txBusy |=> txRun)
    else $error("transmit side stopped mid-character");
endmodule
